// ==== rtl/mfgt_ctrl.sv ====
/*
 Manufacturing pin-test control: decodes the load and snapshot vendor
 requests, holds the six-byte test vector, overrides the non-USB
 outputs in test mode and serves the pin snapshot.
 Assumes a control-pipe front end that presents each setup packet as a
 one-cycle strobe, delivers OUT data bytes with a valid strobe, pulls IN
 bytes with a ready strobe, and turns req_stall into a STALL handshake.
*/
`timescale 1ns/1ps
module mfgt_ctrl (
   input wire logic clk_sys,
   input wire logic reset,
   // Setup packet
   input wire logic setup_valid,
   input wire logic [7:0] setup_req_type,
   input wire logic [7:0] setup_request,
   input wire logic [15:0] setup_value,
   input wire logic [15:0] setup_index,
   input wire logic [15:0] setup_length,
   // OUT data stage
   input wire logic out_valid,
   input wire logic [7:0] out_data,
   // IN data stage
   input wire logic in_ready,
   output logic [7:0] in_data,
   output logic in_valid,
   // Request outcome
   output logic req_stall,
   output logic req_done,
   output logic req_claim,
   // Bridge logic drive and enables
   input wire mfgt_pkg::mfgt_pins_t norm_pins,
   // Asynchronous pin inputs
   input wire mfgt_pkg::mfgt_inputs_t pin_in,
   input wire logic [2:0] gp_in,
   input wire logic [15:0] data_bus_in,
   // Pin drive
   output mfgt_pkg::mfgt_pins_t pin_out,
   output mfgt_pkg::mfgt_pins_t pin_oe,
   output logic test_mode_active
);
   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   localparam int IN_W = $bits(mfgt_pkg::mfgt_inputs_t);
   mfgt_pkg::mfgt_inputs_t in_s;
   logic [2:0] gp_s;
   logic [15:0] bus_s;
   logic [IN_W-1:0] in_s_raw;

   mfgt_sync #(.W(IN_W)) u_sync_in (
      .clk_sys(clk_sys),
      .reset(reset),
      .d(pin_in),
      .q(in_s_raw)
   );
   assign in_s = mfgt_pkg::mfgt_inputs_t'(in_s_raw);

   mfgt_sync #(.W(19)) u_sync_io (
      .clk_sys(clk_sys),
      .reset(reset),
      .d({gp_in, data_bus_in}),
      .q({gp_s, bus_s})
   );

   ////////////////////////////////////////////////////////////////////////
   // Request decode
   logic is_load;
   logic is_snap;
   logic load_ok;
   logic load_leave;
   logic snap_ok;

   assign is_load = setup_valid && setup_req_type == mfgt_pkg::REQTYPE_OUT
      && setup_request == mfgt_pkg::REQ_LOAD;
   assign is_snap = setup_valid && setup_req_type == mfgt_pkg::REQTYPE_IN
      && setup_request == mfgt_pkg::REQ_SNAP;
   // Leaving needs no data stage
   assign load_leave = setup_value == mfgt_pkg::MODE_NORMAL;
   assign load_ok = setup_value == mfgt_pkg::MODE_TEST
      && setup_length <= mfgt_pkg::LOAD_LEN_MAX;
   assign snap_ok = setup_value == mfgt_pkg::ZERO_WORD
      && setup_index == mfgt_pkg::ZERO_WORD
      && setup_length != mfgt_pkg::ZERO_WORD
      && setup_length <= mfgt_pkg::SNAP_LEN_MAX;
   // Claim either vendor request for the front end
   assign req_claim = is_load || is_snap;

   ////////////////////////////////////////////////////////////////////////
   // Control state
   mfgt_pkg::mfgt_state_t state_r, state_nxt;
   logic test_r, test_nxt;
   logic [7:0] vec_r [6], vec_nxt [6];
   logic [7:0] stage_r [6], stage_nxt [6];
   logic [2:0] ptr_r, ptr_nxt;
   logic [3:0] left_r, left_nxt;
   logic [7:0] snap_r [8], snap_nxt [8];
   logic [7:0] snap_cap [8];
   logic stall_r, stall_nxt;
   logic done_r, done_nxt;

   always_comb
   begin
      state_nxt = state_r;
      test_nxt = test_r;
      vec_nxt = vec_r;
      stage_nxt = stage_r;
      ptr_nxt = ptr_r;
      left_nxt = left_r;
      snap_nxt = snap_r;
      stall_nxt = 1'b0;
      done_nxt = 1'b0;
      case (state_r)
         mfgt_pkg::MFGT_IDLE:
         begin
            if (is_load)
            begin
               if (load_leave)
               begin
                  test_nxt = 1'b0;
                  done_nxt = 1'b1;
               end
               else if (load_ok && setup_length != mfgt_pkg::ZERO_WORD)
               begin
                  ptr_nxt = setup_index[2:0];
                  left_nxt = setup_length[3:0];
                  stage_nxt = vec_r;
                  state_nxt = mfgt_pkg::MFGT_LOAD;
               end
               else if (load_ok)
               begin
                  test_nxt = 1'b1;
                  done_nxt = 1'b1;
               end
               else
                  stall_nxt = 1'b1;
            end
            else if (is_snap)
            begin
               if (snap_ok)
               begin
                  snap_nxt = snap_cap;
                  ptr_nxt = 3'h0;
                  left_nxt = setup_length[3:0];
                  state_nxt = mfgt_pkg::MFGT_SNAP;
               end
               else
                  stall_nxt = 1'b1;
            end
         end
         mfgt_pkg::MFGT_LOAD:
         begin
            if (out_valid)
            begin
               // Bytes at offsets 6 and 7 are dropped; the 3-bit pointer then wraps to byte 0
               if (ptr_r < 3'd6)
                  stage_nxt[ptr_r] = out_data;
               ptr_nxt = ptr_r + 3'd1;
               left_nxt = left_r - 4'd1;
               if (left_r == 4'd1)
               begin
                  // Vector applied only once the stage completes
                  vec_nxt = stage_nxt;
                  test_nxt = 1'b1;
                  done_nxt = 1'b1;
                  state_nxt = mfgt_pkg::MFGT_IDLE;
               end
            end
            // New setup aborts; partial vector discarded
            if (setup_valid)
               state_nxt = mfgt_pkg::MFGT_IDLE;
         end
         mfgt_pkg::MFGT_SNAP:
         begin
            if (in_ready)
            begin
               ptr_nxt = ptr_r + 3'd1;
               left_nxt = left_r - 4'd1;
               if (left_r == 4'd1)
               begin
                  done_nxt = 1'b1;
                  state_nxt = mfgt_pkg::MFGT_IDLE;
               end
            end
            // New setup aborts the IN stage
            if (setup_valid)
               state_nxt = mfgt_pkg::MFGT_IDLE;
         end
         default:
            state_nxt = mfgt_pkg::MFGT_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         state_r <= mfgt_pkg::MFGT_IDLE;
         test_r <= 1'b0;
         ptr_r <= 3'h0;
         left_r <= 4'h0;
         stall_r <= 1'b0;
         done_r <= 1'b0;
         for (int i = 0; i < 6; i++)
         begin
            vec_r[i] <= mfgt_pkg::VEC_RESET;
            stage_r[i] <= mfgt_pkg::VEC_RESET;
         end
         for (int i = 0; i < 8; i++)
            snap_r[i] <= mfgt_pkg::VEC_RESET;
      end
      else
      begin
         state_r <= state_nxt;
         test_r <= test_nxt;
         ptr_r <= ptr_nxt;
         left_r <= left_nxt;
         stall_r <= stall_nxt;
         done_r <= done_nxt;
         vec_r <= vec_nxt;
         stage_r <= stage_nxt;
         snap_r <= snap_nxt;
      end
   end

   // Outcome pulses and the byte under the pointer
   assign req_stall = stall_r;
   assign req_done = done_r;
   assign test_mode_active = test_r;
   assign in_valid = state_r == mfgt_pkg::MFGT_SNAP;
   assign in_data = snap_r[ptr_r];

   ////////////////////////////////////////////////////////////////////////
   // Test vector to pin values
   mfgt_pkg::mfgt_pins_t tv;
   mfgt_pkg::mfgt_pins_t toe;
   logic [7:0] b0, b1, b4;

   assign b0 = vec_r[mfgt_pkg::VEC_STROBES];
   assign b1 = vec_r[mfgt_pkg::VEC_SELECT];
   assign b4 = vec_r[mfgt_pkg::VEC_GP];

   always_comb
   begin
      tv = '0;
      toe = '1;
      tv.low_power_out = b0[mfgt_pkg::B0_LOW_POWER_OUT];
      tv.high_power_request_n = b0[mfgt_pkg::B0_HIPWR];
      tv.storage_reset_n = b0[mfgt_pkg::B0_RST];
      tv.write_strobe_n = b0[mfgt_pkg::B0_WR];
      tv.read_strobe_n = b0[mfgt_pkg::B0_RD];
      tv.dma_ack_n = b0[mfgt_pkg::B0_DACK];
      tv.storage_pullup_enable = b0[mfgt_pkg::B0_PU];
      tv.chip_select_n = b1[mfgt_pkg::B1_CS_LO +: 2];
      tv.register_addr_lines = b1[mfgt_pkg::B1_DA_LO +: 3];
      tv.serial_clock = b1[mfgt_pkg::B1_SCL];
      tv.data_bus_output_enable = b1[mfgt_pkg::B1_DDEN];
      tv.storage_data_bus = {vec_r[mfgt_pkg::VEC_BUS_HI],
         vec_r[mfgt_pkg::VEC_BUS_LO]};
      tv.gp_out = b4[mfgt_pkg::B4_GP_LO +: 3];
      tv.gp_oe = b4[mfgt_pkg::B4_GPEN_LO +: 3];
      // High-Z controls from bytes 1 and 4
      toe.storage_data_bus = {16{b1[mfgt_pkg::B1_DDEN]}};
      toe.gp_out = b4[mfgt_pkg::B4_GPEN_LO +: 3];
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin cells
   localparam int PW = $bits(mfgt_pkg::mfgt_pins_t);
   // Open-drain pins within the packed struct
   localparam logic [PW-1:0] OD_MASK = PW'({1'b1, 1'b1, 5'h00, 2'h0,
      3'h0, 1'b1, 16'h0000, 1'b0, 3'h0, 3'h0});
   logic [PW-1:0] nv, no, tvv, tvo, po, poe;
   mfgt_pkg::mfgt_pins_t noe;

   // Bridge enables: data bus and GP pins follow their own fields
   always_comb
   begin
      noe = '1;
      noe.storage_data_bus = {16{norm_pins.data_bus_output_enable}};
      noe.gp_out = norm_pins.gp_oe;
   end

   assign nv = norm_pins;
   assign no = noe;
   assign tvv = tv;
   assign tvo = toe;

   // One cell per pin; test flag picks the source
   for (genvar g = 0; g < PW; g++)
   begin : g_cell
      mfgt_pin_cell #(.OPEN_DRAIN(OD_MASK[g])) u_cell (
         .test_sel(test_r),
         .norm_val(nv[g]),
         .norm_oe(no[g]),
         .test_val(tvv[g]),
         .test_oe(tvo[g]),
         .pin_o(po[g]),
         .pin_oe(poe[g])
      );
   end
   assign pin_out = po;
   assign pin_oe = poe;

   ////////////////////////////////////////////////////////////////////////
   // Snapshot capture
   // Frozen into snap_r on the setup edge
   mfgt_pkg::mfgt_pins_t lvl;
   assign lvl = po;

   always_comb
   begin
      snap_cap[0] = {in_s.eject_request_n, in_s.dma_request, in_s.io_ready,
         in_s.system_interrupt, in_s.disk_ready, in_s.bus_powered,
         in_s.bus_power_valid, in_s.drive_power_valid};
      snap_cap[1] = {lvl.read_strobe_n, lvl.write_strobe_n,
         lvl.storage_reset_n, poe[PW-2] ? 1'b0 : 1'b1, 1'b0,
         poe[PW-1] ? 1'b0 : 1'b1, 1'b1, in_s.storage_interrupt};
      snap_cap[2] = {lvl.register_addr_lines, lvl.chip_select_n, 1'b0,
         lvl.storage_pullup_enable, lvl.dma_ack_n};
      snap_cap[3] = bus_s[7:0];
      snap_cap[4] = bus_s[15:8];
      snap_cap[5] = {poe[5:3], lvl.data_bus_output_enable, 1'b0, gp_s};
      snap_cap[6] = {6'h3F, in_s.storage_port_enable, test_r};
      snap_cap[7] = mfgt_pkg::ALL_ONES;
   end
endmodule // mfgt_ctrl

// ==== rtl/mfgt_pin_cell.sv ====
/*
 One output pin cell: selects bridge or test value and handles
 open-drain behaviour.
 Assumes the enable inputs are already resolved by the caller.
*/
`timescale 1ns/1ps
module mfgt_pin_cell #(
   parameter bit OPEN_DRAIN = 1'b0
) (
   input wire logic test_sel,
   input wire logic norm_val,
   input wire logic norm_oe,
   input wire logic test_val,
   input wire logic test_oe,
   output logic pin_o,
   output logic pin_oe
);
   logic val;
   logic oe;

   assign val = test_sel ? test_val : norm_val;
   assign oe = test_sel ? test_oe : norm_oe;
   // Open drain: only a low is ever driven
   assign pin_o = OPEN_DRAIN ? 1'b0 : val;
   assign pin_oe = OPEN_DRAIN ? (oe & ~val) : oe;
endmodule // mfgt_pin_cell

// ==== rtl/mfgt_pkg.sv ====
/*
 Package for the manufacturing pin-test block: request codes, vector
 field positions, pin groups carried as packed structs.
 Assumes a control-pipe front end that decodes setup packets and moves
 data-stage bytes one at a time.
*/
package mfgt_pkg;
   // Request codes
   localparam logic [7:0] REQTYPE_OUT = 8'h40;
   localparam logic [7:0] REQTYPE_IN = 8'hC0;
   localparam logic [7:0] REQ_LOAD = 8'h05;
   localparam logic [7:0] REQ_SNAP = 8'h06;
   localparam logic [15:0] MODE_NORMAL = 16'h0000;
   localparam logic [15:0] MODE_TEST = 16'h0001;
   localparam logic [15:0] ZERO_WORD = 16'h0000;
   localparam logic [15:0] LOAD_LEN_MAX = 16'h0007;
   localparam logic [15:0] SNAP_LEN_MAX = 16'h0008;
   // Vector byte offsets
   localparam logic [2:0] VEC_STROBES = 3'h0;
   localparam logic [2:0] VEC_SELECT = 3'h1;
   localparam logic [2:0] VEC_BUS_LO = 3'h2;
   localparam logic [2:0] VEC_BUS_HI = 3'h3;
   localparam logic [2:0] VEC_GP = 3'h4;
   localparam logic [2:0] VEC_SPARE = 3'h5;
   // Vector byte 0 fields
   localparam int B0_LOW_POWER_OUT = 0;
   localparam int B0_HIPWR = 2;
   localparam int B0_RST = 3;
   localparam int B0_WR = 4;
   localparam int B0_RD = 5;
   localparam int B0_DACK = 6;
   localparam int B0_PU = 7;
   // Vector byte 1 fields
   localparam int B1_CS_LO = 1;
   localparam int B1_DA_LO = 3;
   localparam int B1_SCL = 6;
   localparam int B1_DDEN = 7;
   // Vector byte 4 fields
   localparam int B4_GP_LO = 0;
   localparam int B4_GPEN_LO = 4;
   // Reset value of the vector bytes
   localparam logic [7:0] VEC_RESET = 8'h00;
   localparam logic [7:0] ALL_ONES = 8'hFF;

   // Outputs owned by the test block or by the bridge
   typedef struct packed {
      logic low_power_out;
      logic high_power_request_n;
      logic storage_reset_n;
      logic write_strobe_n;
      logic read_strobe_n;
      logic dma_ack_n;
      logic storage_pullup_enable;
      logic [1:0] chip_select_n;
      logic [2:0] register_addr_lines;
      logic serial_clock;
      logic [15:0] storage_data_bus;
      logic data_bus_output_enable;
      logic [2:0] gp_out;
      logic [2:0] gp_oe;
   } mfgt_pins_t;

   // Plain inputs sampled by the snapshot
   typedef struct packed {
      logic drive_power_valid;
      logic bus_power_valid;
      logic bus_powered;
      logic disk_ready;
      logic system_interrupt;
      logic io_ready;
      logic dma_request;
      logic eject_request_n;
      logic storage_interrupt;
      logic storage_port_enable;
   } mfgt_inputs_t;

   typedef enum logic [3:0] {
      MFGT_IDLE = 4'b0001,
      MFGT_LOAD = 4'b0010,
      MFGT_SNAP = 4'b0100,
      MFGT_STALL = 4'b1000
   } mfgt_state_t;
endpackage

// ==== rtl/mfgt_sync.sv ====
/*
 Two-flop synchroniser, parameterised width.
 Assumes the input is asynchronous to clk_sys.
*/
`timescale 1ns/1ps
module mfgt_sync #(
   parameter int W = 1
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         meta_r <= '0;
         q_r <= '0;
      end
      else
      begin
         meta_r <= d;
         q_r <= meta_r;
      end
   end

   assign q = q_r;
endmodule // mfgt_sync

// ==== verification/mfgt_ctrl_sva.sv ====
/*
 Checker for mfgt_ctrl: request answers, pin takeover, output holds.
 Bound into every mfgt_ctrl; sees only its ports.
*/
`timescale 1ns/1ps
module mfgt_ctrl_sva (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic setup_valid,
   input wire logic [7:0] setup_req_type,
   input wire logic [7:0] setup_request,
   input wire logic [15:0] setup_value,
   input wire logic [15:0] setup_index,
   input wire logic [15:0] setup_length,
   input wire logic in_ready,
   input wire logic [7:0] in_data,
   input wire logic in_valid,
   input wire logic req_stall,
   input wire logic req_done,
   input wire logic req_claim,
   input wire mfgt_pkg::mfgt_pins_t norm_pins,
   input wire mfgt_pkg::mfgt_pins_t pin_out,
   input wire mfgt_pkg::mfgt_pins_t pin_oe,
   input wire logic test_mode_active
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   logic ld;
   logic sn;
   assign ld = setup_valid && setup_req_type == 8'h40
      && setup_request == mfgt_pkg::REQ_LOAD;
   assign sn = setup_valid && setup_req_type == 8'hC0
      && setup_request == mfgt_pkg::REQ_SNAP;

   a_load_bad_mode: assert property (ld && setup_value > 16'h0001
      |=> req_stall ##1 test_mode_active == $past(test_mode_active, 2))
      else $error("bad load mode not refused");
   a_load_too_long: assert property (ld && setup_value == 16'h0001
      && setup_length > 16'h0007 |=> req_stall)
      else $error("long load not stalled");
   a_snap_too_long: assert property (sn && setup_length > 16'h0008
      |=> req_stall)
      else $error("long snapshot not stalled");
   a_snap_start: assert property (sn && setup_value == 16'h0000
      && setup_index == 16'h0000 && setup_length inside {[1:8]}
      |=> in_valid && !req_stall)
      else $error("snapshot not served");
   a_mode_exit: assert property (ld && setup_value == 16'h0000
      |=> req_done ##1 !test_mode_active)
      else $error("normal mode not restored");
   a_normal_pins: assert property (!test_mode_active
      |-> pin_out.write_strobe_n == norm_pins.write_strobe_n
      && pin_out.storage_data_bus == norm_pins.storage_data_bus
      && pin_oe.storage_data_bus
      == {16{norm_pins.data_bus_output_enable}})
      else $error("normal pins not followed");
   a_open_drain: assert property (!(pin_oe.low_power_out
      && pin_out.low_power_out) && !(pin_oe.serial_clock
      && pin_out.serial_clock) && !(pin_oe.high_power_request_n
      && pin_out.high_power_request_n))
      else $error("open drain driven high");
   a_claim_decode: assert property (req_claim == (ld || sn))
      else $error("request claim wrong");
   a_in_hold: assert property (in_valid && !in_ready
      |=> in_valid && $stable(in_data))
      else $error("snapshot byte not held");
   c_load: cover property (ld && setup_value == 16'h0001 ##1 !req_stall);
   c_snap: cover property (in_valid && in_ready);
   c_stall: cover property (req_stall);
endmodule // mfgt_ctrl_sva

bind mfgt_ctrl mfgt_ctrl_sva mfgt_ctrl_sva_inst (.*);

// ==== verification/mfgt_ctrl_test.sv ====
/*
 Self-checking bench for mfgt_ctrl: loads, snapshots, refusals.
 Host model drives the control side; the bench drives the pins.
*/
`timescale 1ns/1ps
module mfgt_ctrl_test;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic setup_valid, out_valid, in_ready, in_valid;
   logic req_stall, req_done, test_mode_active;
   logic [7:0] setup_req_type, setup_request, out_data, in_data;
   logic [15:0] setup_value, setup_index, setup_length, data_bus_in;
   logic [15:0] ext_bus = 16'h9C3E;
   logic [2:0] gp_in;
   logic [2:0] ext_gp = 3'h2;
   mfgt_pkg::mfgt_pins_t norm_pins = 36'h5_A5C3_3C96;
   mfgt_pkg::mfgt_pins_t pin_out, pin_oe;
   mfgt_pkg::mfgt_inputs_t pin_in = 10'h2B5;
   int n_errors = 0;
   int samples_checked = 0;
   logic [55:0] vecs [2] = '{56'h00_FF25_A63C_D5B5, 56'h5A_009B_7711_2B4A};
   logic [63:0] bad [6] = '{64'h4005_0002_0000_0007,
      64'h4005_0001_0000_0008, 64'hC006_0000_0000_0009,
      64'hC006_0000_0000_0000, 64'hC006_0001_0000_0001,
      64'hC006_0000_0001_0001};

   always #5 clk_sys = ~clk_sys;
   // Pins read back as the resolved wire
   assign data_bus_in = (pin_oe.storage_data_bus & pin_out.storage_data_bus)
      | (~pin_oe.storage_data_bus & ext_bus);
   assign gp_in = (pin_out.gp_oe & pin_out.gp_out) | (~pin_out.gp_oe & ext_gp);

   mfgt_ctrl mfgt_ctrl_inst (.*, .req_claim());
   mfgt_host_model mfgt_host_model_inst (.*);

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [63:0] exp_snap(input logic [55:0] v,
      input logic tm);
      logic [7:0] r0;
      logic [15:0] bus;
      logic [2:0] gp;
      for (int i = 0; i < 8; i++)
         r0[i] = pin_in[9 - i];
      bus = v[15] ? v[31:16] : ext_bus;
      gp = (v[34:32] & v[38:36]) | (ext_gp & ~v[38:36]);
      return {8'hFF, 6'h3F, pin_in.storage_port_enable, tm, v[38:36], v[15],
         1'b0, gp, bus, v[13:9], 1'b0, v[7:6], v[5:2], 1'b0, v[0], 1'b1,
         pin_in.storage_interrupt, r0};
   endfunction

   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [63:0] e, g);
      samples_checked++;
      if (g !== e)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic resp(input string what, input logic s);
      chk(what, 64'(s), 64'(mfgt_host_model_inst.stalled));
      if (mfgt_host_model_inst.hung)
      begin
         n_errors++;
         test_done();
      end
   endtask

   task automatic snap_chk(input logic [15:0] l, input logic [55:0] v,
      input logic tm, input logic [63:0] m);
      repeat (4) @(posedge clk_sys);
      #1;
      mfgt_host_model_inst.snap(l);
      resp("snapshot", 1'b0);
      chk("snapshot", exp_snap(v, tm) & m, mfgt_host_model_inst.got & m);
   endtask

   initial
   begin
      logic [55:0] v;
      repeat (10) @(posedge clk_sys);
      #1;
      reset = 1'b0;
      chk("mode", 64'h0, 64'(test_mode_active));
      snap_chk(16'h0001, 56'h0, 1'b0, 64'hFF);
      $display("test short snapshot done");
      foreach (vecs[j])
      begin
         v = vecs[j];
         mfgt_host_model_inst.load(16'h0001, 16'h0007, v);
         resp("load", 1'b0);
         chk("mode", 64'h1, 64'(test_mode_active));
         chk("strobe", 64'(v[4]), 64'(pin_out.write_strobe_n));
         chk("drain oe", 64'(!v[0]), 64'(pin_oe.low_power_out));
         snap_chk(16'h0008, v, 1'b1, 64'hFFFF_FFFF_FFFB_F7FF);
      end
      $display("test vector loads done");
      foreach (bad[j])
      begin
         mfgt_host_model_inst.req(bad[j]);
         mfgt_host_model_inst.fin();
         resp("refusal", 1'b1);
         chk("mode kept", 64'h1, 64'(test_mode_active));
      end
      $display("test refused requests done");
      mfgt_host_model_inst.load(16'h0000, 16'h0000, 56'h0);
      resp("leave", 1'b0);
      chk("mode", 64'h0, 64'(test_mode_active));
      snap_chk(16'h0008, 56'h0, 1'b0, 64'hFFFF_08FF_FF00_03FF);
      $display("test leave test mode done");
      test_done();
   end

   initial
   begin
      repeat (20000) @(posedge clk_sys);
      n_errors++;
      test_done();
   end
endmodule // mfgt_ctrl_test

// ==== verification/mfgt_host_model.sv ====
/*
 Host model issuing load and snapshot vendor requests.
 Tasks are entered 1 ns after a rising clk_sys edge.
*/
`timescale 1ns/1ps
module mfgt_host_model (
   input wire logic clk_sys,
   output logic setup_valid,
   output logic [7:0] setup_req_type,
   output logic [7:0] setup_request,
   output logic [15:0] setup_value,
   output logic [15:0] setup_index,
   output logic [15:0] setup_length,
   output logic out_valid,
   output logic [7:0] out_data,
   output logic in_ready,
   input wire logic [7:0] in_data,
   input wire logic in_valid,
   input wire logic req_stall,
   input wire logic req_done
);
   logic [63:0] stp = 64'h0;
   logic [63:0] got;
   logic stalled;
   logic hung;
   assign {setup_req_type, setup_request, setup_value, setup_index,
      setup_length} = stp;
   initial
   begin
      setup_valid = 1'b0;
      out_valid = 1'b0;
      out_data = 8'h00;
      in_ready = 1'b0;
   end

   // Fields scrambled once the strobe falls
   task automatic req(input logic [63:0] s);
      stp = s;
      setup_valid = 1'b1;
      @(posedge clk_sys);
      #1;
      setup_valid = 1'b0;
      stp = ~s;
   endtask

   task automatic fin();
      int n;
      n = 0;
      while (!req_done && !req_stall && n < 40)
      begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      hung = n == 40;
      stalled = req_stall;
      @(posedge clk_sys);
      #1;
   endtask

   task automatic load(input logic [15:0] v, l, input logic [55:0] d);
      req({8'h40, 8'h05, v, 16'h0000, l});
      for (int k = 0; k < 7 && k < int'(l) && !req_stall; k++)
      begin
         out_valid = 1'b1;
         out_data = d[8*k +: 8];
         @(posedge clk_sys);
         #1;
      end
      out_valid = 1'b0;
      out_data = ~out_data;
      fin();
   endtask

   task automatic snap(input logic [15:0] l);
      got = 'x;
      req({8'hC0, 8'h06, 32'h0000_0000, l});
      // First byte held one cycle before it is taken
      @(posedge clk_sys);
      #1;
      in_ready = in_valid;
      for (int k = 0; k < 8 && k < int'(l) && in_valid; k++)
      begin
         got[8*k +: 8] = in_data;
         @(posedge clk_sys);
         #1;
      end
      in_ready = 1'b0;
      fin();
   endtask
endmodule // mfgt_host_model
